// file: hdl/accel_pkg.sv
package accel_pkg;
    localparam int          CLK_HZ      = 25_000_000;
    localparam int          AMP_HZ      = 61_500;
    localparam int          MOD_HZ      = 20_500;
    localparam int          AMP_DIV     = CLK_HZ / AMP_HZ;
    localparam int          AMP_PER_MOD = AMP_HZ / MOD_HZ;
    localparam int          TON_PERIODS = 5;
    localparam int          OUT_W       = 16;
    localparam int          TRIM_N      = 6;
    localparam int          DEC_MAX     = 512;
    localparam logic [6:0]  SLAVE_ADDR  = 7'h1d;
    // Register map
    localparam logic [6:0]  REG_CTRL1   = 7'h20;
    localparam logic [6:0]  REG_CTRL2   = 7'h21;
    localparam logic [6:0]  REG_THS     = 7'h22;
    localparam logic [6:0]  REG_INT_SRC = 7'h23;
    localparam logic [6:0]  REG_STATUS  = 7'h27;
    localparam logic [6:0]  REG_OUT_XL  = 7'h28;
    localparam logic [6:0]  REG_OUT_ZH  = 7'h2d;
    // Field positions
    localparam int          C1_POWER    = 6;
    localparam int          C1_RATE     = 4;
    localparam int          C2_SIM      = 0;
    localparam int          C2_RDY_PIN  = 1;
    localparam int          C2_INT_EN   = 2;
    localparam int          C2_MODE     = 4;
    localparam logic [7:0]  CTRL1_RST   = 8'h07;
    localparam logic [7:0]  CTRL2_RST   = 8'h02;
    localparam logic [7:0]  THS_RST     = 8'h10;
    localparam int          THS_SHIFT   = 4;

    typedef enum logic [1:0] {EV_WAKE, EV_DIR, EV_FALL, EV_NONE} ev_mode_t;

    // Decimation factor 512, 128, 32, 8 for rate codes 0..3
    function automatic logic [9:0] dec_of(input logic [1:0] rate);
        return 10'(DEC_MAX >> (2 * rate));
    endfunction

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction
endpackage

// file: hdl/axis_filter.sv
module axis_filter import accel_pkg::*; #(
    parameter int W = OUT_W
) (
    input  wire logic                clk,
    input  wire logic                reset,
    // Modulator side
    input  wire logic                tick,
    input  wire logic                bit_in,
    input  wire logic                run,
    input  wire logic [1:0]          rate,
    // Word side
    output logic signed [W-1:0]      word,
    output logic                     done
);
    logic [9:0] ones;
    logic [9:0] count;
    logic [9:0] total;

    assign total = ones + {9'h0, bit_in};

    // Count ones over one decimation window, then centre and scale
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (reset || !run) begin
            ones  <= 10'h0;
            count <= 10'h0;
            if (reset)
                word <= '0;
        end else if (tick) begin
            if (count == dec_of(rate) - 10'h1) begin
                word  <= W'(($signed({1'b0, total, 1'b0}) - $signed({2'b0, dec_of(rate)}))
                         <<< (2 * rate));
                ones  <= 10'h0;
                count <= 10'h0;
                done  <= 1'b1;
            end else begin
                ones  <= total;
                count <= count + 10'h1;
            end
        end
    end
endmodule // axis_filter

// file: hdl/accel_readout_serial_front.sv
module accel_readout_serial_front import accel_pkg::*; (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Analogue front end
    output logic             AMP_SAMPLE,
    output logic             MOD_SAMPLE,
    input  wire logic [2:0]  MOD_BITS,
    // Trim storage
    output logic [2:0]       NVM_ADDR,
    input  wire logic [7:0]  NVM_DATA,
    // Serial pads
    input  wire logic        CS,
    input  wire logic        SCL_CLK,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_N,
    output logic             SOL_OUT,
    output logic             SOL_OE_N,
    // Event pin
    output logic             RDY_INT
);
    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_MACK} i2c_st_t;
    typedef enum logic [1:0] {K_ADDR, K_SUB, K_DATA} kind_t;

    logic [2:0]  cs_q, scl_q, sda_q;
    logic [2:0]  bits_m, bits_s;
    logic        cs_s, scl_s, sda_s, scl_d, sda_d, rise, fall, start, stop;
    logic [8:0]  amp_cnt;
    logic [1:0]  amp_ph;
    logic [2:0]  trim_idx;
    logic        trim_done;
    logic [7:0]  trim [TRIM_N];
    logic [7:0]  ctrl1, ctrl2, ths, int_src;
    logic [7:0]  out_b [6];
    logic signed [OUT_W-1:0] raw [3];
    logic signed [OUT_W-1:0] prev [3];
    logic [2:0]  done3;
    logic        run, valid, drdy;
    logic [2:0]  ton_cnt;
    // I2C side
    i2c_st_t     ist;
    kind_t       kind;
    logic [3:0]  icnt;
    logic [7:0]  ish, itx;
    logic [6:0]  iptr;
    logic        iai, irw, idrive;
    logic        i_wr, i_rd;
    logic [6:0]  i_a;
    logic [7:0]  i_d;
    // SPI side
    logic [2:0]  scnt;
    logic [7:0]  ssh, stx;
    logic [6:0]  sptr;
    logic        shdr, srw, sms, sout, sdrive;
    logic        s_wr, s_rd;
    logic [6:0]  s_a;
    logic [7:0]  s_d;
    logic        wr_ev, rd_ev, set_drdy;
    logic [6:0]  wr_a, rd_a;
    logic [7:0]  wr_d;
    logic [2:0]  ev_now;
    logic [7:0]  i_rdv, s_rdv;

    function automatic logic [7:0] rd(input logic [6:0] a);
        case (a)
            REG_CTRL1:   rd = ctrl1;
            REG_CTRL2:   rd = ctrl2;
            REG_THS:     rd = ths;
            REG_INT_SRC: rd = int_src;
            REG_STATUS:  rd = {4'h0, trim_done, valid, |int_src, drdy};
            default:     rd = (a >= REG_OUT_XL && a <= REG_OUT_ZH) ? out_b[3'(a - REG_OUT_XL)]
                                                                    : 8'h00;
        endcase
    endfunction

    // Read data at each interface's current pointer
    always_comb begin
        i_rdv = rd(iptr);
        s_rdv = rd(sptr);
    end

    // Remove zero offset and correct gain
    function automatic logic [OUT_W-1:0] cal(input logic signed [OUT_W-1:0] v,
                                             input logic [7:0] off, input logic [7:0] gain);
        logic signed [OUT_W:0]   d;
        logic signed [OUT_W+9:0] p;
        d = $signed({v[OUT_W-1], v}) - $signed({{(OUT_W-7){off[7]}}, off});
        p = d * $signed({1'b0, 9'h80} + {{2{gain[7]}}, gain});
        return p[OUT_W+6:7];
    endfunction

    // Pad and bitstream synchronisers
    always_ff @(posedge CLK) begin
        cs_q   <= {cs_q[1], cs_q[0], CS};
        scl_q  <= {scl_q[1], scl_q[0], SCL_CLK};
        sda_q  <= {sda_q[1], sda_q[0], SDA_IN};
        bits_m <= MOD_BITS;
        bits_s <= bits_m;
    end
    assign cs_s  = cs_q[1];
    assign scl_s = scl_q[1];
    assign sda_s = sda_q[1];
    assign scl_d = scl_q[2];
    assign sda_d = sda_q[2];
    assign rise  = scl_s && !scl_d;
    assign fall  = !scl_s && scl_d;
    assign start = cs_s && scl_s && scl_d && sda_d && !sda_s;
    assign stop  = cs_s && scl_s && scl_d && !sda_d && sda_s;

    // Sample strobes for amplifier and modulators
    always_ff @(posedge CLK) begin
        AMP_SAMPLE <= 1'b0;
        MOD_SAMPLE <= 1'b0;
        if (RESET) begin
            amp_cnt <= 9'h0;
            amp_ph  <= 2'h0;
        end else if (amp_cnt == 9'(AMP_DIV - 1)) begin
            amp_cnt    <= 9'h0;
            AMP_SAMPLE <= 1'b1;
            amp_ph     <= (amp_ph == 2'(AMP_PER_MOD - 1)) ? 2'h0 : amp_ph + 2'h1;
            MOD_SAMPLE <= (amp_ph == 2'(AMP_PER_MOD - 1));
        end else begin
            amp_cnt <= amp_cnt + 9'h1;
        end
    end

    // Trim download; storage answers one cycle after the address
    always_ff @(posedge CLK) begin
        if (RESET) begin
            trim_idx  <= 3'h0;
            trim_done <= 1'b0;
            for (int i = 0; i < TRIM_N; i++)
                trim[i] <= 8'h00;
        end else if (!trim_done) begin
            if (trim_idx != 3'h0)
                trim[trim_idx - 3'h1] <= NVM_DATA;
            trim_idx  <= (trim_idx == 3'(TRIM_N)) ? trim_idx : trim_idx + 3'h1;
            trim_done <= (trim_idx == 3'(TRIM_N));
        end
    end
    assign NVM_ADDR = trim_idx;

    assign run = trim_done && ctrl1[C1_POWER];

    for (genvar g = 0; g < 3; g++) begin : g_axis
        axis_filter #(.W(OUT_W)) u_filt (
            .clk    (CLK),
            .reset  (RESET),
            .tick   (MOD_SAMPLE),
            .bit_in (bits_s[g]),
            .run    (run),
            .rate   (ctrl1[C1_RATE +: 2]),
            .word   (raw[g]),
            .done   (done3[g])
        );
    end

    // Turn-on delay and output capture
    always_ff @(posedge CLK) begin
        if (RESET || !run) begin
            ton_cnt <= 3'h0;
            valid   <= 1'b0;
        end else if (done3[0]) begin
            if (ton_cnt != 3'(TON_PERIODS))
                ton_cnt <= ton_cnt + 3'h1;
            valid <= (ton_cnt >= 3'(TON_PERIODS - 1));
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < 6; i++)
                out_b[i] <= 8'h00;
            for (int i = 0; i < 3; i++)
                prev[i] <= '0;
        end else if (done3[0]) begin
            for (int i = 0; i < 3; i++) begin
                {out_b[2*i+1], out_b[2*i]} <= cal(raw[i], trim[2*i], trim[2*i+1]);
                prev[i] <= raw[i];
            end
        end
    end

    assign set_drdy = done3[0] && ton_cnt >= 3'(TON_PERIODS - 1);

    always_ff @(posedge CLK) begin
        if (RESET || !run)
            drdy <= 1'b0;
        else if (set_drdy)
            drdy <= 1'b1;
        else if (rd_ev && rd_a == REG_OUT_ZH)
            drdy <= 1'b0;
    end

    // Inertial events on enabled axes
    always_comb begin
        ev_now = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (ctrl1[i] && abs16(raw[i]) > (16'(ths) << THS_SHIFT))
                ev_now[EV_WAKE] = 1'b1;
            if (ctrl1[i] && raw[i][OUT_W-1] != prev[i][OUT_W-1])
                ev_now[EV_DIR] = 1'b1;
        end
        ev_now[EV_FALL] = |ctrl1[2:0];
        for (int i = 0; i < 3; i++)
            if (ctrl1[i] && abs16(raw[i]) >= (16'(ths) << THS_SHIFT))
                ev_now[EV_FALL] = 1'b0;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            int_src <= 8'h00;
        end else begin
            for (int i = 0; i < 3; i++)
                if (set_drdy && valid && ev_now[i] && ctrl2[C2_MODE +: 2] == 2'(i))
                    int_src[i] <= 1'b1;
                else if (rd_ev && rd_a == REG_INT_SRC)
                    int_src[i] <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET)
            RDY_INT <= 1'b0;
        else
            RDY_INT <= ctrl2[C2_RDY_PIN] ? drdy : (ctrl2[C2_INT_EN] && |int_src);
    end

    // Register writes from whichever interface is selected
    assign wr_ev = cs_s ? i_wr : s_wr;
    assign wr_a  = cs_s ? i_a  : s_a;
    assign wr_d  = cs_s ? i_d  : s_d;
    assign rd_ev = cs_s ? i_rd : s_rd;
    assign rd_a  = cs_s ? i_a  : s_a;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl1 <= CTRL1_RST;
            ctrl2 <= CTRL2_RST;
            ths   <= THS_RST;
        end else if (wr_ev) begin
            case (wr_a)
                REG_CTRL1: ctrl1 <= wr_d;
                REG_CTRL2: ctrl2 <= wr_d;
                REG_THS:   ths   <= wr_d;
                default:   ;
            endcase
        end
    end

    // I2C slave
    always_ff @(posedge CLK) begin
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        if (RESET || !cs_s || stop) begin
            ist    <= I_IDLE;
            idrive <= 1'b0;
            kind   <= K_ADDR;
            icnt   <= 4'h0;
            ish    <= 8'h00;
            itx    <= 8'h00;
            iptr   <= 7'h0;
            iai    <= 1'b0;
            irw    <= 1'b0;
            i_a    <= 7'h0;
            i_d    <= 8'h00;
        end else if (start) begin
            ist    <= I_RX;
            kind   <= K_ADDR;
            icnt   <= 4'h0;
            idrive <= 1'b0;
        end else begin
            case (ist)
                I_RX: begin
                    if (rise) begin
                        ish  <= {ish[6:0], sda_s};
                        icnt <= icnt + 4'h1;
                    end else if (fall && icnt == 4'h8) begin
                        icnt <= 4'h0;
                        if (kind == K_ADDR && ish[7:1] != SLAVE_ADDR) begin
                            ist <= I_IDLE;
                        end else begin
                            ist    <= I_ACK;
                            idrive <= 1'b1;
                            case (kind)
                                K_ADDR: irw <= ish[0];
                                K_SUB: begin
                                    iptr <= ish[6:0];
                                    iai  <= ish[7];
                                end
                                default: begin
                                    i_wr <= 1'b1;
                                    i_a  <= iptr;
                                    i_d  <= ish;
                                    iptr <= iptr + {6'h0, iai};
                                end
                            endcase
                        end
                    end
                end
                I_ACK: begin
                    if (fall) begin
                        if (kind == K_ADDR && irw) begin
                            ist    <= I_TX;
                            itx    <= i_rdv;
                            idrive <= !i_rdv[7];
                            i_rd   <= 1'b1;
                            i_a    <= iptr;
                            iptr   <= iptr + {6'h0, iai};
                        end else begin
                            ist    <= I_RX;
                            idrive <= 1'b0;
                            kind   <= (kind == K_ADDR) ? K_SUB : K_DATA;
                        end
                    end
                end
                I_TX: begin
                    if (rise) begin
                        icnt <= icnt + 4'h1;
                    end else if (fall) begin
                        if (icnt == 4'h8) begin
                            ist    <= I_MACK;
                            idrive <= 1'b0;
                            icnt   <= 4'h0;
                        end else begin
                            itx    <= {itx[6:0], 1'b0};
                            idrive <= !itx[6];
                        end
                    end
                end
                I_MACK: begin
                    if (rise && sda_s) begin
                        ist <= I_IDLE;
                    end else if (fall) begin
                        ist    <= I_TX;
                        itx    <= i_rdv;
                        idrive <= !i_rdv[7];
                        i_rd   <= 1'b1;
                        i_a    <= iptr;
                        iptr   <= iptr + {6'h0, iai};
                    end
                end
                default: idrive <= 1'b0;
            endcase
        end
    end

    // SPI slave: sample on rising clock, shift out on falling clock
    always_ff @(posedge CLK) begin
        s_wr <= 1'b0;
        s_rd <= 1'b0;
        if (RESET || cs_s) begin
            scnt   <= 3'h0;
            ssh    <= 8'h00;
            stx    <= 8'h00;
            sptr   <= 7'h0;
            shdr   <= 1'b0;
            srw    <= 1'b0;
            sms    <= 1'b0;
            sout   <= 1'b0;
            sdrive <= 1'b0;
            s_a    <= 7'h0;
            s_d    <= 8'h00;
        end else if (rise) begin
            ssh  <= {ssh[6:0], sda_s};
            scnt <= scnt + 3'h1;
            if (scnt == 3'h7) begin
                if (!shdr) begin
                    shdr <= 1'b1;
                    srw  <= ssh[6];
                    sms  <= ssh[5];
                    sptr <= {1'b0, ssh[4:0], sda_s};
                end else if (!srw) begin
                    s_wr <= 1'b1;
                    s_a  <= sptr;
                    s_d  <= {ssh[6:0], sda_s};
                    sptr <= sptr + {6'h0, sms};
                end
            end
        end else if (fall && shdr && srw) begin
            if (scnt == 3'h0) begin
                stx    <= s_rdv;
                sout   <= s_rdv[7];
                sdrive <= 1'b1;
                s_rd   <= 1'b1;
                s_a    <= sptr;
                sptr   <= sptr + {6'h0, sms};
            end else begin
                stx  <= {stx[6:0], 1'b0};
                sout <= stx[6];
            end
        end
    end

    // Shared pads: open-drain in I2C, push-pull data in SPI
    assign SDA_OUT  = cs_s ? 1'b0 : sout;
    assign SDA_OE_N = cs_s ? !idrive : !(sdrive && ctrl2[C2_SIM]);
    assign SOL_OUT  = sout;
    assign SOL_OE_N = cs_s || !(sdrive && !ctrl2[C2_SIM]);
endmodule // accel_readout_serial_front

// file: verification/accel_front_sva.sv
module accel_front_sva import accel_pkg::*; (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RESET,
    // Front end and trim
    input wire logic       AMP_SAMPLE,
    input wire logic       MOD_SAMPLE,
    input wire logic [2:0] MOD_BITS,
    input wire logic [2:0] NVM_ADDR,
    input wire logic [7:0] NVM_DATA,
    // Pads and event pin
    input wire logic       CS,
    input wire logic       SCL_CLK,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE_N,
    input wire logic       SOL_OUT,
    input wire logic       SOL_OE_N,
    input wire logic       RDY_INT
);
    logic [8:0]  amp_gap;
    logic [1:0]  amp_n;
    logic [10:0] mod_age;
    logic        amp_seen;
    logic        mod_seen;

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // Cycles since the last amplifier strobe
    always_ff @(posedge CLK) begin
        amp_gap  <= (RESET || AMP_SAMPLE) ? 9'h000 : amp_gap + 9'h001;
        amp_seen <= !RESET && (amp_seen || AMP_SAMPLE);
    end

    // Amplifier strobes between modulator strobes
    always_ff @(posedge CLK) begin
        amp_n    <= (RESET || MOD_SAMPLE) ? 2'h0 : amp_n + {1'b0, AMP_SAMPLE};
        mod_seen <= !RESET && (mod_seen || MOD_SAMPLE);
    end

    // Age of the last modulator strobe, saturating
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mod_age <= 11'h7ff;
        end else if (MOD_SAMPLE) begin
            mod_age <= 11'h000;
        end else if (mod_age != 11'h7ff) begin
            mod_age <= mod_age + 11'h001;
        end
    end

    a_amp_period: assert property (AMP_SAMPLE && amp_seen |-> amp_gap == 9'(AMP_DIV - 1))
        else $error("amplifier strobe period wrong");
    a_mod_on_amp: assert property (MOD_SAMPLE |-> AMP_SAMPLE)
        else $error("modulator strobe not on an amplifier strobe");
    a_mod_third: assert property (MOD_SAMPLE && mod_seen |-> amp_n == 2'h2)
        else $error("modulator strobe not every third amplifier strobe");
    a_reset_idle: assert property (disable iff (1'b0) RESET |=>
        SDA_OE_N && SOL_OE_N && !RDY_INT)
        else $error("pads driven or event pin high in reset");
    a_i2c_no_sdo: assert property (CS [*8] |-> SOL_OE_N)
        else $error("four-wire output driven while two-wire selected");
    a_i2c_drain: assert property (CS [*8] ##0 !SDA_OE_N |-> !SDA_OUT)
        else $error("two-wire data driven high");
    a_one_driver: assert property (!SOL_OE_N |-> SDA_OE_N)
        else $error("both data outputs driven");
    a_cs_release: assert property ($rose(CS) |-> ##5 SOL_OE_N && SDA_OE_N)
        else $error("outputs still driven after deselect");
    a_rdy_cause: assert property ($rose(RDY_INT) |-> mod_age < 11'h12c)
        else $error("event pin rose away from a filter update");
    a_trim_range: assert property (NVM_ADDR <= 3'h6)
        else $error("trim address out of range");

    cover property ($rose(RDY_INT));
    cover property (!SOL_OE_N);
    cover property (!CS && !SDA_OE_N);
    cover property (CS && !SDA_OE_N);
endmodule // accel_front_sva

bind accel_readout_serial_front accel_front_sva chk (.CLK(CLK), .RESET(RESET),
    .AMP_SAMPLE(AMP_SAMPLE), .MOD_SAMPLE(MOD_SAMPLE), .MOD_BITS(MOD_BITS), .NVM_ADDR(NVM_ADDR),
    .NVM_DATA(NVM_DATA), .CS(CS), .SCL_CLK(SCL_CLK), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .SOL_OUT(SOL_OUT), .SOL_OE_N(SOL_OE_N), .RDY_INT(RDY_INT));

// file: verification/host_master.sv
module host_master (
    // Clock
    input  wire logic       CLK,
    // Pads
    output logic            CS,
    output logic            SCL_CLK,
    output logic            SDA_IN,
    input  wire logic       SDA_OUT,
    input  wire logic       SDA_OE_N,
    input  wire logic       SOL_OUT,
    input  wire logic       SOL_OE_N,
    // Results
    output logic            got,
    output logic [7:0]      got_val
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quarter bit of 16 clocks keeps the two-wire clock near 390 kHz
    localparam int Q = 16;
    logic rel;
    logic sda;

    // Wired-and with the on-chip pull-up
    assign SDA_IN = (rel | sda) & ((SDA_OE_N !== 1'b0) | SDA_OUT);

    initial begin
        CS = 1'b1;
        SCL_CLK = 1'b1;
        rel = 1'b1;
        sda = 1'b1;
        got = 1'b0;
        got_val = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic emit(input logic [7:0] v);
        got_val = v;
        got = ~got;
    endtask

    task automatic spi(input logic rd, input logic [5:0] a, input logic [7:0] d, input logic w3);
        logic [15:0] f;
        logic [7:0]  r;
        f = {rd, 1'b0, a, d};
        CS = 1'b0;
        hold(4);
        for (int i = 15; i >= 0; i--) begin
            SCL_CLK = 1'b0;
            rel = rd && i < 8;
            sda = f[i];
            hold(4);
            SCL_CLK = 1'b1;
            if (i < 8) r[i] = w3 ? SDA_IN : (SOL_OE_N === 1'b0 ? SOL_OUT : 1'bx);
            hold(4);
        end
        CS = 1'b1;
        rel = 1'b1;
        hold(8);
        if (rd) emit(r);
    endtask

    task automatic ibit(input logic b, output logic s);
        hold(Q);
        rel = b;
        sda = 1'b0;
        hold(Q);
        SCL_CLK = 1'b1;
        hold(Q);
        s = SDA_IN;
        hold(Q);
        SCL_CLK = 1'b0;
    endtask

    task automatic start;
        hold(Q);
        rel = 1'b1;
        hold(Q);
        SCL_CLK = 1'b1;
        hold(Q);
        rel = 1'b0;
        sda = 1'b0;
        hold(Q);
        SCL_CLK = 1'b0;
    endtask

    task automatic xbyte(input logic [7:0] b, input logic rx);
        logic [7:0] r;
        logic       s;
        for (int i = 7; i >= 0; i--) ibit(b[i], r[i]);
        ibit(1'b1, s);
        emit(rx ? r : {7'h00, s});
    endtask

    task automatic i2c(input logic [6:0] sad, input logic [7:0] sub, input logic [7:0] d,
                       input logic rd);
        start();
        xbyte({sad, 1'b0}, 1'b0);
        xbyte(sub, 1'b0);
        if (rd) begin
            start();
            xbyte({sad, 1'b1}, 1'b0);
            xbyte(8'hff, 1'b1);
        end else begin
            xbyte(d, 1'b0);
        end
        hold(Q);
        rel = 1'b0;
        sda = 1'b0;
        hold(Q);
        SCL_CLK = 1'b1;
        hold(Q);
        rel = 1'b1;
        hold(Q);
    endtask
endmodule // host_master

// file: verification/accel_readout_serial_front_tb.sv
module accel_readout_serial_front_tb import accel_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {string nm; logic [7:0] v; logic [7:0] m;} note_t;
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        AMP_SAMPLE, MOD_SAMPLE, CS, SCL_CLK, SDA_IN, SDA_OUT, SDA_OE_N;
    logic        SOL_OUT, SOL_OE_N, RDY_INT, got;
    logic [2:0]  MOD_BITS = 3'h0;
    logic [2:0]  NVM_ADDR;
    logic [7:0]  NVM_DATA = 8'h00;
    logic [7:0]  got_val;
    logic [31:0] rng = 32'h00000043;
    logic [5:0]  ra[6] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h27, 6'h3f};
    logic [7:0]  rv[6] = '{8'h07, 8'h02, 8'h10, 8'h00, 8'h08, 8'h00};
    int          num_errors = 0;
    int          n_compared = 0;
    int          mods = 0;
    int          cyc = 0;
    int          m0;
    note_t       notes[$];

    always #20 CLK = ~CLK;

    accel_readout_serial_front dut (.CLK(CLK), .RESET(RESET), .AMP_SAMPLE(AMP_SAMPLE),
        .MOD_SAMPLE(MOD_SAMPLE), .MOD_BITS(MOD_BITS), .NVM_ADDR(NVM_ADDR), .NVM_DATA(NVM_DATA),
        .CS(CS), .SCL_CLK(SCL_CLK), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
        .SOL_OUT(SOL_OUT), .SOL_OE_N(SOL_OE_N), .RDY_INT(RDY_INT));
    host_master host (.CLK(CLK), .CS(CS), .SCL_CLK(SCL_CLK), .SDA_IN(SDA_IN),
        .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SOL_OUT(SOL_OUT), .SOL_OE_N(SOL_OE_N),
        .got(got), .got_val(got_val));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic note(input string nm, input logic [7:0] v, input logic [7:0] m = 8'hff);
        notes.push_back('{nm, v, m});
    endtask

    task automatic rd(input logic [6:0] a, input logic w3 = 1'b0);
        host.spi(1'b1, a[5:0], 8'h00, w3);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic w3 = 1'b0);
        host.spi(1'b0, a[5:0], d, w3);
    endtask

    task automatic wait_rdy;
        while (RDY_INT !== 1'b1) @(posedge CLK);
        #1;
    endtask

    task automatic test_done;
        $display("Checks %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Random bitstreams, trim storage answering one cycle later, hang guard
    always @(posedge CLK) begin
        rng = xs(rng);
        MOD_BITS <= #1 rng[2:0];
        NVM_DATA <= #1 {5'h00, NVM_ADDR};
        cyc++;
        if (MOD_SAMPLE === 1'b1) mods++;
        if (cyc == 95000) begin
            num_errors++;
            test_done();
        end
    end

    always @(got) begin : mon
        note_t n;
        if (cyc > 0) begin
            n = notes.pop_front();
            check(n.nm, got_val & n.m, n.v & n.m);
        end
    end

    initial begin
        logic [7:0] d;
        repeat (5) @(posedge CLK);
        #1 RESET = 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        foreach (ra[i]) begin
            note("reset value", rv[i]);
            rd({1'b0, ra[i]});
        end
        d = rng[7:0];
        wr(REG_THS, d);
        wr(REG_STATUS, 8'hff);
        note("threshold", d);
        rd(REG_THS);
        note("status kept", 8'h08);
        rd(REG_STATUS);
        wr(REG_CTRL2, 8'h03);
        note("three-wire read", 8'h03);
        rd(REG_CTRL2, 1'b1);
        wr(REG_CTRL2, CTRL2_RST, 1'b1);
        note("four-wire read", CTRL2_RST);
        rd(REG_CTRL2);
        d = rng[15:8];
        repeat (3) note("slave ack", 8'h00);
        host.i2c(SLAVE_ADDR, {1'b0, REG_THS}, d, 1'b0);
        repeat (3) note("slave ack", 8'h00);
        note("two-wire read", d);
        host.i2c(SLAVE_ADDR, {1'b0, REG_THS}, 8'h00, 1'b1);
        repeat (3) note("foreign address", 8'h01);
        host.i2c(SLAVE_ADDR ^ 7'h01, {1'b0, REG_THS}, ~d, 1'b0);
        note("threshold kept", d);
        rd(REG_THS);
        wr(REG_THS, 8'hff);
        wr(REG_CTRL1, 8'h77);
        m0 = mods;
        wait_rdy();
        check("turn-on ticks", 8'((mods - m0) inside {[39:41]}), 8'h01);
        m0 = mods;
        note("status ready", 8'h0d);
        rd(REG_STATUS);
        note("z high", 8'h00, 8'h00);
        rd(REG_OUT_ZH);
        check("ready cleared", {7'h00, RDY_INT}, 8'h00);
        wait_rdy();
        check("ticks per word", 8'(mods - m0), 8'h08);
        note("event flush", 8'h00);
        rd(REG_INT_SRC);
        wr(REG_CTRL2, 8'h24);
        wait_rdy();
        note("free-fall source", 8'h04);
        rd(REG_INT_SRC);
        test_done();
    end
endmodule // accel_readout_serial_front_tb
